// File: src/cbs_divider.sv
`timescale 1ns/1ps
module cbs_divider #(
  parameter int W = cbs_pkg::DIV_W
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  output logic [W-1:0] taps, // Divider taps, bit n-1 is Qn
  output logic [W-1:0] tap_rise // One-cycle pulse per rising tap
);

  logic [W-1:0] next_taps;
  logic [W-1:0] next_rise;

  // Free-running binary count; rise marks bits going 0 to 1
  always_comb begin
    next_taps = taps + {{(W-1){1'b0}}, 1'b1};
    next_rise = next_taps & ~taps;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      taps <= '0;
      tap_rise <= '0;
    end else begin
      taps <= next_taps;
      tap_rise <= next_rise;
    end
  end

endmodule : cbs_divider

// File: src/cbs_pkg.sv
package cbs_pkg;

  // Clock and timing figures
  localparam int CLK_HZ = 125_000_000;
  localparam int CB_PHASE_MS = 100;
  localparam int CB_PHASE_CYCLES = CB_PHASE_MS * (CLK_HZ / 1000);
  localparam int ZERO_US = 18;
  localparam int ONE_US = 50;
  localparam int STROBE_US = 200;
  // Decision bounds sit midway between the nominal pulse widths
  localparam int ONE_MIN_US = (ZERO_US + ONE_US) / 2;
  localparam int STROBE_MIN_US = (ONE_US + STROBE_US) / 2;
  localparam int ONE_MIN_CYCLES = ONE_MIN_US * (CLK_HZ / 1_000_000);
  localparam int STROBE_MIN_CYCLES = STROBE_MIN_US * (CLK_HZ / 1_000_000);

  // Divider tap positions, tap Qn sits at bit n-1
  localparam int DIV_W = 6;
  localparam int TAP_Q2 = 1;
  localparam int TAP_Q3 = 2;
  localparam int TAP_Q4 = 3;
  localparam int TAP_Q5 = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETTLE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_CB_COUNT = 8'h14;
  localparam logic [7:0] OFS_SS_COUNT = 8'h18;
  localparam logic [7:0] OFS_CTRL_WORD = 8'h1C;

  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CW_START = 0;
  localparam int IRQ_CB_END = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_WORD = 2;
  localparam int IRQ_W = 3;
  localparam int SETTLE_W = 16;
  localparam int WORD_W = 16;

  // Reset values
  localparam logic [SETTLE_W-1:0] SETTLE_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_BALANCE,
    ST_SLOPE
  } cbs_state_type;

  // Integrator current switches
  typedef struct packed {
    logic input_connect;
    logic cb_current;
    logic ss_current;
  } cbs_analog_type;

endpackage : cbs_pkg

// File: src/cbs_pulse_decoder.sv
`timescale 1ns/1ps
module cbs_pulse_decoder #(
  parameter int W = cbs_pkg::WORD_W,
  parameter int ONE_MIN = cbs_pkg::ONE_MIN_CYCLES,
  parameter int STROBE_MIN = cbs_pkg::STROBE_MIN_CYCLES
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic serial_in, // Pulse-width coded control line
  output logic [W-1:0] word, // Last latched control word
  output logic word_valid // One-cycle pulse on latch
);

  localparam int CW = $clog2(STROBE_MIN + 1);

  logic prev;
  logic [CW-1:0] width;
  logic [W-1:0] shift;
  logic next_prev;
  logic [CW-1:0] next_width;
  logic [W-1:0] next_shift;
  logic [W-1:0] next_word;
  logic next_valid;

  // Width measured while high, classified on the falling edge
  always_comb begin
    next_prev = serial_in;
    next_width = width;
    next_shift = shift;
    next_word = word;
    next_valid = 1'b0;
    if (serial_in) begin
      // Saturate so a stuck-high line still reads as a strobe
      if (width != CW'(STROBE_MIN)) begin
        next_width = width + {{(CW-1){1'b0}}, 1'b1};
      end
    end else begin
      next_width = '0;
    end
    if (prev && !serial_in) begin
      if (width >= CW'(STROBE_MIN)) begin
        next_word = shift;
        next_valid = 1'b1;
      end else begin
        next_shift = {shift[W-2:0], (width >= CW'(ONE_MIN))};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
      width <= '0;
      shift <= '0;
      word <= '0;
      word_valid <= 1'b0;
    end else begin
      prev <= next_prev;
      width <= next_width;
      shift <= next_shift;
      word <= next_word;
      word_valid <= next_valid;
    end
  end

endmodule : cbs_pulse_decoder

// File: src/cbs_sequencer.sv
`timescale 1ns/1ps
module cbs_sequencer #(
  parameter int CB_CYCLES = cbs_pkg::CB_PHASE_CYCLES,
  parameter int ONE_MIN = cbs_pkg::ONE_MIN_CYCLES,
  parameter int STROBE_MIN = cbs_pkg::STROBE_MIN_CYCLES
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic cb_comp_above, // Integrator above balance threshold
  input wire logic ss_comp_pos, // Integrator still positive
  input wire logic ctl_serial_in, // Coded control line from host
  output cbs_pkg::cbs_analog_type analog, // Integrator current switches
  output logic count_pulse, // One-cycle pulse per count
  output logic irq // Level interrupt
);

  localparam int PW = $clog2(CB_CYCLES + 1);

  // True where the offset names a register
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == cbs_pkg::OFS_CTRL) || (a == cbs_pkg::OFS_SETTLE)
      || (a == cbs_pkg::OFS_STATUS) || (a == cbs_pkg::OFS_IRQ_STATUS)
      || (a == cbs_pkg::OFS_IRQ_MASK) || (a == cbs_pkg::OFS_CB_COUNT)
      || (a == cbs_pkg::OFS_SS_COUNT) || (a == cbs_pkg::OFS_CTRL_WORD);
  endfunction : reg_hit

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  logic [cbs_pkg::DIV_W-1:0] taps;
  logic [cbs_pkg::DIV_W-1:0] tap_rise;
  logic [cbs_pkg::WORD_W-1:0] ctrl_word;
  logic word_valid;

  cbs_divider #(.W(cbs_pkg::DIV_W)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .taps(taps),
    .tap_rise(tap_rise)
  );

  cbs_pulse_decoder #(
    .W(cbs_pkg::WORD_W),
    .ONE_MIN(ONE_MIN),
    .STROBE_MIN(STROBE_MIN)
  ) u_dec (
    .aclk(aclk),
    .aresetn(aresetn),
    .serial_in(ctl_serial_in),
    .word(ctrl_word),
    .word_valid(word_valid)
  );

  // Bus-side state
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [cbs_pkg::SETTLE_W-1:0] settle;
  logic [cbs_pkg::IRQ_W-1:0] irq_status, irq_mask;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  logic [cbs_pkg::SETTLE_W-1:0] next_settle;
  logic [cbs_pkg::IRQ_W-1:0] next_irq_status, next_irq_mask;
  logic do_write, do_read, start_req, abort_req;
  logic [cbs_pkg::IRQ_W-1:0] events;
  logic [31:0] rd_mux, wr_val, settle_wr, mask_wr;

  // Sequencer state
  cbs_pkg::cbs_state_type state, next_state;
  logic cb_ff, next_cb_ff;
  logic [PW-1:0] phase_cnt, next_phase_cnt;
  logic [cbs_pkg::SETTLE_W-1:0] settle_cnt, next_settle_cnt;
  logic [31:0] cb_count, ss_count, next_cb_count, next_ss_count;
  cbs_pkg::cbs_analog_type next_analog;
  logic next_pulse;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && !s_axi_rvalid;
  assign wr_val = merge(32'h0000_0000, w_data, w_strb);
  assign settle_wr = merge({16'h0000, settle}, w_data, w_strb);
  assign mask_wr = merge({29'h0, irq_mask}, w_data, w_strb);
  assign start_req = (do_write && aw_addr == cbs_pkg::OFS_CTRL && wr_val[cbs_pkg::CTRL_START])
    || (word_valid && ctrl_word[cbs_pkg::CW_START]);
  assign abort_req = do_write && aw_addr == cbs_pkg::OFS_CTRL && wr_val[cbs_pkg::CTRL_ABORT];

  // Read mux; status shows state, balance latch and comparators
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      cbs_pkg::OFS_SETTLE: rd_mux = {16'h0000, settle};
      cbs_pkg::OFS_STATUS: rd_mux = {27'h0, ss_comp_pos, cb_comp_above, cb_ff, state};
      cbs_pkg::OFS_IRQ_STATUS: rd_mux = {29'h0, irq_status};
      cbs_pkg::OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      cbs_pkg::OFS_CB_COUNT: rd_mux = cb_count;
      cbs_pkg::OFS_SS_COUNT: rd_mux = ss_count;
      cbs_pkg::OFS_CTRL_WORD: rd_mux = {16'h0000, ctrl_word};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave and register file; address and data taken in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_settle = settle;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_hit(aw_addr) ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
      if (aw_addr == cbs_pkg::OFS_SETTLE) begin
        next_settle = settle_wr[cbs_pkg::SETTLE_W-1:0];
      end
      if (aw_addr == cbs_pkg::OFS_IRQ_MASK) begin
        next_irq_mask = mask_wr[cbs_pkg::IRQ_W-1:0];
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rdata = rd_mux;
      next_rresp = reg_hit(s_axi_araddr) ? cbs_pkg::RESP_OKAY : cbs_pkg::RESP_SLVERR;
      if (s_axi_araddr == cbs_pkg::OFS_IRQ_STATUS) begin
        next_irq_status = '0;
      end
    end
    // A new event wins over a clear in the same cycle
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cbs_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cbs_pkg::RESP_OKAY;
      settle <= cbs_pkg::SETTLE_RESET;
      irq_mask <= cbs_pkg::IRQ_MASK_RESET;
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      settle <= next_settle;
      irq_mask <= next_irq_mask;
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

  // Conversion sequencer: settle, balance, slope, back to idle
  always_comb begin
    next_state = state;
    next_cb_ff = cb_ff;
    next_phase_cnt = phase_cnt;
    next_settle_cnt = settle_cnt;
    next_cb_count = cb_count;
    next_ss_count = ss_count;
    next_pulse = 1'b0;
    events = '0;
    events[cbs_pkg::IRQ_WORD] = word_valid;
    case (state)
      cbs_pkg::ST_IDLE: begin
        next_cb_ff = 1'b0;
        if (start_req) begin
          next_state = cbs_pkg::ST_SETTLE;
          next_settle_cnt = settle;
        end
      end
      cbs_pkg::ST_SETTLE: begin
        // Lets the host hold the input off while its selection settles
        if (settle_cnt == '0) begin
          next_state = cbs_pkg::ST_BALANCE;
          next_phase_cnt = PW'(CB_CYCLES - 1);
          next_cb_count = 32'h0000_0000;
        end else begin
          next_settle_cnt = settle_cnt - {{(cbs_pkg::SETTLE_W-1){1'b0}}, 1'b1};
        end
      end
      cbs_pkg::ST_BALANCE: begin
        // Clear wins so the latch cannot stick when Q3..Q5 meet Q4's rise
        if (taps[cbs_pkg::TAP_Q3] && taps[cbs_pkg::TAP_Q4] && taps[cbs_pkg::TAP_Q5]) begin
          next_cb_ff = 1'b0;
        end else if (tap_rise[cbs_pkg::TAP_Q4] && cb_comp_above) begin
          next_cb_ff = 1'b1;
        end
        if (tap_rise[cbs_pkg::TAP_Q2] && cb_ff) begin
          next_pulse = 1'b1;
          next_cb_count = cb_count + 32'h0000_0001;
        end
        if (phase_cnt == '0) begin
          next_state = cbs_pkg::ST_SLOPE;
          next_cb_ff = 1'b0;
          next_ss_count = 32'h0000_0000;
          events[cbs_pkg::IRQ_CB_END] = 1'b1;
        end else begin
          next_phase_cnt = phase_cnt - {{(PW-1){1'b0}}, 1'b1};
        end
      end
      cbs_pkg::ST_SLOPE: begin
        if (!ss_comp_pos) begin
          next_state = cbs_pkg::ST_IDLE;
          events[cbs_pkg::IRQ_DONE] = 1'b1;
        end else if (tap_rise[cbs_pkg::TAP_Q2]) begin
          next_pulse = 1'b1;
          next_ss_count = ss_count + 32'h0000_0001;
        end
      end
      default: next_state = cbs_pkg::ST_IDLE;
    endcase
    if (abort_req) begin
      next_state = cbs_pkg::ST_IDLE;
      next_cb_ff = 1'b0;
    end
    // Switches follow the next state so they move with it
    next_analog.input_connect = (next_state == cbs_pkg::ST_BALANCE);
    next_analog.cb_current = next_cb_ff && (next_state == cbs_pkg::ST_BALANCE);
    next_analog.ss_current = (next_state == cbs_pkg::ST_SLOPE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= cbs_pkg::ST_IDLE;
      cb_ff <= 1'b0;
      phase_cnt <= '0;
      settle_cnt <= '0;
      cb_count <= 32'h0000_0000;
      ss_count <= 32'h0000_0000;
      analog <= '0;
      count_pulse <= 1'b0;
    end else begin
      state <= next_state;
      cb_ff <= next_cb_ff;
      phase_cnt <= next_phase_cnt;
      settle_cnt <= next_settle_cnt;
      cb_count <= next_cb_count;
      ss_count <= next_ss_count;
      analog <= next_analog;
      count_pulse <= next_pulse;
    end
  end

endmodule : cbs_sequencer

// File: tb/cbs_host_model.sv
`timescale 1ns/1ps
module cbs_host_model #(
  parameter int ZERO_W = 2,
  parameter int ONE_W = 10,
  parameter int STROBE_W = 30
) (
  input wire logic aclk, // Clock
  input wire logic count_pulse, // Pulse from converter
  output logic ctl_serial_in // Coded control line
);
  int pulse_total = 0; // Never cleared, bench takes differences
  logic [7:0] timer = 8'h00; // Host 8-bit pulse timer
  int ext_cnt = 0; // Extension count, stepped down per timer wrap

  initial ctl_serial_in = 1'b0;

  // Host tally of converter pulses; wrap kept cheap for the host
  always @(posedge aclk) begin
    if (count_pulse) begin
      pulse_total <= pulse_total + 1;
      timer <= timer + 8'h01;
      if (timer == 8'hFF) begin
        ext_cnt <= ext_cnt - 1;
      end
    end
  end

  // Line returns low between pulses so each width is measured alone
  task automatic pulse(input int w);
    ctl_serial_in <= 1'b1;
    repeat (w) @(posedge aclk);
    ctl_serial_in <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse

  task automatic send_word(input logic [15:0] wd);
    for (int i = 15; i >= 0; i--) begin
      pulse(wd[i] ? ONE_W : ZERO_W);
    end
    pulse(STROBE_W);
  endtask : send_word
endmodule : cbs_host_model

// File: tb/cbs_sequencer_checker.sv
`timescale 1ns/1ps
module cbs_sequencer_checker #(
  parameter int CB_CYCLES = cbs_pkg::CB_PHASE_CYCLES
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic ss_comp_pos, // Slope comparator
  input wire cbs_pkg::cbs_analog_type analog, // Current switches
  input wire logic count_pulse // Count pulse
);
  default clocking cb_clk @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  int bal_cnt; // Cycles with input connected
  int next_bal_cnt;
  logic off_q; // All sources off last cycle
  logic next_off_q;
  logic all_off;

  // Phase length and idle tracking
  always_comb begin
    all_off = !analog.input_connect && !analog.ss_current;
    next_off_q = all_off;
    next_bal_cnt = analog.input_connect ? bal_cnt + 1 : 0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bal_cnt <= 0;
      off_q <= 1'b0;
    end else begin
      bal_cnt <= next_bal_cnt;
      off_q <= next_off_q;
    end
  end

  // Latch window: set on tap four, cleared at taps three to five, at phase end or on abort
  sequence s_cb_on;
    $rose(analog.cb_current);
  endsequence
  // Phase end or abort may cut a packet short, so only a drop in balance counts
  sequence s_cb_held;
    (analog.cb_current || !analog.input_connect) [*3];
  endsequence

  AST_CB_HOLD: assert property (s_cb_on |-> s_cb_held)
    else $error("balance current dropped too early");
  AST_CB_GAP: assert property ($fell(analog.cb_current) |=> !analog.cb_current [*8])
    else $error("balance current set off tap four");
  AST_CB_GATED: assert property (analog.cb_current |-> analog.input_connect)
    else $error("balance current outside balance phase");
  AST_ONE_SOURCE: assert property (analog.ss_current |-> all_off == 1'b0 && !analog.input_connect
    && !analog.cb_current)
    else $error("slope current with other sources on");
  AST_SLOPE_ENTRY: assert property ($rose(analog.ss_current) |-> $past(analog.input_connect))
    else $error("slope phase not preceded by balance");
  AST_BAL_LEN: assert property ($rose(analog.ss_current) |-> bal_cnt == CB_CYCLES)
    else $error("balance phase length wrong");
  AST_PULSE_GAP: assert property (count_pulse |=> !count_pulse [*3])
    else $error("count pulses closer than tap two period");
  AST_SLOPE_STOP: assert property (analog.ss_current && !ss_comp_pos
    |-> ##[1:4] !analog.ss_current)
    else $error("slope phase not ended by comparator");
  AST_IDLE_QUIET: assert property (all_off && off_q |-> !count_pulse)
    else $error("count pulse while idle");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule : cbs_sequencer_checker

// File: tb/charge_balance_adc_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

bind cbs_sequencer cbs_sequencer_checker #(.CB_CYCLES(CB_CYCLES)) u_cbs_sequencer_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .ss_comp_pos(ss_comp_pos), .analog(analog), .count_pulse(count_pulse));

module charge_balance_adc_sequencer_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, cb_comp_above, ss_comp_pos, ctl_serial_in, count_pulse, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  cbs_pkg::cbs_analog_type analog;
  int bad_count = 0;
  int check_count = 0;

  cbs_sequencer #(.CB_CYCLES(200), .ONE_MIN(5), .STROBE_MIN(20)) u_cbs_sequencer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cb_comp_above(cb_comp_above),
    .ss_comp_pos(ss_comp_pos), .ctl_serial_in(ctl_serial_in), .analog(analog),
    .count_pulse(count_pulse), .irq(irq));

  cbs_host_model u_cbs_host_model (
    .aclk(aclk), .count_pulse(count_pulse), .ctl_serial_in(ctl_serial_in));

  always #4 aclk = ~aclk;

  // Extra edge at the end keeps ready from being set twice in one step
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic write_check(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axi_write(a, d, r);
    `CHK(r, er)
  endtask : write_check

  task automatic read_check(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask : read_check

  task automatic wait_sw(input int idx, input logic lvl);
    int n;
    n = 0;
    while (analog[idx] !== lvl && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    `CHK(analog[idx], lvl)
  endtask : wait_sw

  task automatic t_regs();
    read_check(cbs_pkg::OFS_SETTLE, 32'h0, cbs_pkg::RESP_OKAY);
    read_check(cbs_pkg::OFS_IRQ_MASK, 32'h0, cbs_pkg::RESP_OKAY);
    write_check(cbs_pkg::OFS_SETTLE, 32'hFFFF0003, cbs_pkg::RESP_OKAY);
    read_check(cbs_pkg::OFS_SETTLE, 32'h3, cbs_pkg::RESP_OKAY);
    write_check(8'h40, 32'h1, cbs_pkg::RESP_SLVERR);
    read_check(8'h40, 32'h0, cbs_pkg::RESP_SLVERR);
  endtask : t_regs

  // Word with start bit clear, so no conversion follows
  task automatic t_word();
    u_cbs_host_model.send_word(16'hA5C2);
    `CHK(irq, 1'b0)
    write_check(cbs_pkg::OFS_IRQ_MASK, 32'h4, cbs_pkg::RESP_OKAY);
    `CHK(irq, 1'b1)
    read_check(cbs_pkg::OFS_CTRL_WORD, 32'hA5C2, cbs_pkg::RESP_OKAY);
    read_check(cbs_pkg::OFS_IRQ_STATUS, 32'h4, cbs_pkg::RESP_OKAY);
    read_check(cbs_pkg::OFS_IRQ_STATUS, 32'h0, cbs_pkg::RESP_OKAY);
    `CHK(irq, 1'b0)
    write_check(cbs_pkg::OFS_IRQ_MASK, 32'h7, cbs_pkg::RESP_OKAY);
  endtask : t_word

  // Window counts: ten balance pulses per 64 cycles, one slope pulse per 4
  task automatic t_conv(input logic above, input int slope_len);
    logic [31:0] cbn;
    logic [31:0] ssn;
    logic [1:0] r;
    int p0;
    p0 = u_cbs_host_model.pulse_total;
    cb_comp_above <= above;
    ss_comp_pos <= 1'b1;
    write_check(cbs_pkg::OFS_CTRL, 32'h1, cbs_pkg::RESP_OKAY);
    wait_sw(2, 1'b1);
    wait_sw(0, 1'b1);
    repeat (slope_len) @(posedge aclk);
    ss_comp_pos <= 1'b0;
    wait_sw(0, 1'b0);
    repeat (2) @(posedge aclk);
    `CHK(analog, 3'h0)
    `CHK(irq, 1'b1)
    axi_read(cbs_pkg::OFS_CB_COUNT, cbn, r);
    axi_read(cbs_pkg::OFS_SS_COUNT, ssn, r);
    `CHK(cbn + ssn, 32'(u_cbs_host_model.pulse_total - p0))
    `CHK(above ? (cbn >= 25 && cbn <= 32) : (cbn == 0), 1'b1)
    `CHK(ssn >= slope_len / 4 - 1 && ssn <= slope_len / 4 + 2, 1'b1)
    `CHK(u_cbs_host_model.timer, 8'(u_cbs_host_model.pulse_total))
    `CHK(u_cbs_host_model.ext_cnt, -(u_cbs_host_model.pulse_total / 256))
    read_check(cbs_pkg::OFS_IRQ_STATUS, 32'h3, cbs_pkg::RESP_OKAY);
  endtask : t_conv

  // Abort in mid balance: back to idle, no events, all sources off
  task automatic t_abort();
    write_check(cbs_pkg::OFS_CTRL, 32'h1, cbs_pkg::RESP_OKAY);
    wait_sw(2, 1'b1);
    write_check(cbs_pkg::OFS_CTRL, 32'h2, cbs_pkg::RESP_OKAY);
    `CHK(analog, 3'h0)
    read_check(cbs_pkg::OFS_STATUS, 32'h8, cbs_pkg::RESP_OKAY);
    read_check(cbs_pkg::OFS_IRQ_STATUS, 32'h0, cbs_pkg::RESP_OKAY);
  endtask : t_abort

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Watchdog well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    wrap_up();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    cb_comp_above = 1'b0;
    ss_comp_pos = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(analog, 3'h0)
    `CHK(irq, 1'b0)
    t_regs();
    t_word();
    t_conv(1'b0, 8);
    t_conv(1'b1, 40);
    t_conv(1'b1, 80);
    t_abort();
    wrap_up();
  end
endmodule : charge_balance_adc_sequencer_test
